// ### inc/flash_dl_pkg.sv
package flash_dl_pkg;
  // ************************************************************
  // register map, byte offsets on the register port
  // ************************************************************
  localparam logic [7:0] ADDR_CCS = 8'h00;
  localparam logic [7:0] ADDR_PCS = 8'h01;
  localparam logic [7:0] ADDR_ECS = 8'h02;
  localparam logic [7:0] ADDR_KEY = 8'h03;
  localparam logic [7:0] ADDR_DEST = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CCS_WP_BIT = 7;
  localparam int CCS_ERR_BIT = 4;
  localparam int CCS_RELOC_BIT = 3;
  localparam int CCS_REQ_BIT = 0;
  localparam int SEL_BIT = 0;
  localparam int DEST_ERR_BIT = 7;
  // ************************************************************
  // key codes, destinations, vectors, page size
  // ************************************************************
  localparam logic [7:0] KEY_DOWNLOAD = 8'hA5;
  localparam logic [7:0] KEY_PROGRAM = 8'h5A;
  localparam logic [6:0] DEST_MAX = 7'h03;
  localparam logic [23:0] DEST_BASE0 = 24'hFF7000;
  localparam logic [23:0] DEST_BASE1 = 24'hFFB000;
  localparam logic [23:0] DEST_BASE2 = 24'hFFD000;
  localparam logic [23:0] DEST_BASE3 = 24'hFFE800;
  localparam logic [23:0] RELOC_BASE = 24'hFF8000;
  localparam logic [5:0] VEC_RELOC_LAST = 6'h1F;
  localparam logic [6:0] PAGE_LAST = 7'h7F;
  localparam int ROUTINE_WORDS_DEF = 256;
  typedef enum logic [1:0] {ST_IDLE, ST_DL_COPY, ST_PROG, ST_ERASE} state_t;
endpackage

// ### core/flash_program_download_control.sv
`timescale 1ns/1ps
// Functional notes
// - program/erase only while enable pin high
// - program 128-byte pages, erase whole blocks
// - downloaded routine stays loaded for reuse
// - 8-bit byte registers, reset and standby clear
// - status bit 7 mirrors enable pin
// - error flag blocks further program/erase
// - interrupt or flash read sets error
// - sleep or other bus master sets error
// - only reset or standby clears error
// - relocation maps vectors 0..31 to RAM
// - request bit starts routine download
// - request needs key A5 and RAM execution
// - request bit reads zero, self-clears
// - program select chooses routine, cleared after
// - erase select chooses routine, cleared after
// - program/erase needs key 5A
// - destination codes 0..3 map, others error
module flash_program_download_control
  import flash_dl_pkg::*;
#(
  parameter int ROUTINE_WORDS = ROUTINE_WORDS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic wp_pin,
  input wire logic standby_pin,
  input wire logic exec_in_ram,
  input wire logic irq_event,
  input wire logic flash_read_event,
  input wire logic sleep_event,
  input wire logic other_master_event,
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic [16:0] prog_page,
  input wire logic [3:0] erase_block,
  input wire logic flash_done,
  input wire logic [5:0] vec_num,
  output logic [23:0] vec_addr,
  output logic dl_wr,
  output logic [23:0] dl_addr,
  output logic dl_routine,
  output logic flash_prog,
  output logic flash_erase,
  output logic [23:0] flash_addr,
  output logic [3:0] flash_block,
  output logic pe_busy,
  output logic pe_done,
  output logic pe_fail
);
  // one counter serves copy and page pass, so it never drops below 8 bits
  localparam int CW = ($clog2(ROUTINE_WORDS + 1) > 8) ? $clog2(ROUTINE_WORDS + 1) : 8;
  localparam logic [CW-1:0] COPY_LAST = CW'(ROUTINE_WORDS - 1);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic wp_meta_ff;
  logic wp_ff;
  logic sb_meta_ff;
  logic sb_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_meta_ff <= 1'b0;
      wp_ff <= 1'b0;
      sb_meta_ff <= 1'b0;
      sb_ff <= 1'b0;
    end else begin
      wp_meta_ff <= wp_pin;
      wp_ff <= wp_meta_ff;
      sb_meta_ff <= standby_pin;
      sb_ff <= sb_meta_ff;
    end
  end

  function automatic logic [23:0] dest_base(input logic [1:0] code);
    case (code)
      2'h0: dest_base = DEST_BASE0;
      2'h1: dest_base = DEST_BASE1;
      2'h2: dest_base = DEST_BASE2;
      default: dest_base = DEST_BASE3;
    endcase
  endfunction

  // ************************************************************
  // control state
  // ************************************************************
  state_t state_ff, nxt_state;
  logic err_ff, nxt_err;
  logic reloc_ff, nxt_reloc;
  logic req_ff, nxt_req;
  logic psel_ff, nxt_psel;
  logic esel_ff, nxt_esel;
  logic [7:0] key_ff, nxt_key;
  logic [6:0] dest_ff, nxt_dest;
  logic dest_err_ff, nxt_dest_err;
  logic prog_loaded_ff, nxt_prog_loaded;
  logic erase_loaded_ff, nxt_erase_loaded;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [23:0] base_ff, nxt_base;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [23:0] vec_ff, nxt_vec;
  logic dl_wr_ff, nxt_dl_wr;
  logic [23:0] dl_addr_ff, nxt_dl_addr;
  logic dl_rt_ff, nxt_dl_rt;
  logic fprog_ff, nxt_fprog;
  logic ferase_ff, nxt_ferase;
  logic [23:0] faddr_ff, nxt_faddr;
  logic [3:0] fblock_ff, nxt_fblock;
  logic done_ff, nxt_done;
  logic fail_ff, nxt_fail;

  logic busy;
  logic err_event;
  logic start_ok;

  always_comb begin
    busy = (state_ff == ST_PROG) || (state_ff == ST_ERASE);
    err_event = busy && (irq_event || flash_read_event ||
                         sleep_event || other_master_event);
    start_ok = wp_ff && !err_ff && (key_ff == KEY_PROGRAM);
    nxt_state = state_ff;
    nxt_err = err_ff || err_event;
    nxt_reloc = reloc_ff;
    nxt_req = req_ff;
    nxt_psel = psel_ff;
    nxt_esel = esel_ff;
    nxt_key = key_ff;
    nxt_dest = dest_ff;
    nxt_dest_err = dest_err_ff;
    nxt_prog_loaded = prog_loaded_ff;
    nxt_erase_loaded = erase_loaded_ff;
    nxt_cnt = cnt_ff;
    nxt_base = base_ff;
    nxt_rdata = REG_RESET;
    nxt_dl_wr = 1'b0;
    nxt_dl_addr = dl_addr_ff;
    nxt_dl_rt = dl_rt_ff;
    nxt_fprog = 1'b0;
    nxt_ferase = 1'b0;
    nxt_faddr = faddr_ff;
    nxt_fblock = fblock_ff;
    nxt_done = 1'b0;
    nxt_fail = 1'b0;
    // vectors above 31 are never relocated; software must not use them
    if (reloc_ff && (vec_num <= VEC_RELOC_LAST)) begin
      nxt_vec = RELOC_BASE | {16'h0000, vec_num, 2'b00};
    end else begin
      nxt_vec = {16'h0000, vec_num, 2'b00};
    end

    // ************************************************************
    // register writes
    // ************************************************************
    if (wr) begin
      if (addr == ADDR_CCS) begin
        nxt_reloc = wdata[CCS_RELOC_BIT];
        if (wdata[CCS_REQ_BIT] && (key_ff == KEY_DOWNLOAD) && exec_in_ram &&
            (state_ff == ST_IDLE) && !req_ff) begin
          if (dest_ff > DEST_MAX) begin
            nxt_dest_err = 1'b1;
          end else if (psel_ff || esel_ff) begin
            nxt_req = 1'b1;
            nxt_state = ST_DL_COPY;
            nxt_cnt = '0;
            nxt_dl_rt = !psel_ff;
            nxt_base = dest_base(dest_ff[1:0]);
          end
        end
      end else if (addr == ADDR_PCS) begin
        nxt_psel = wdata[SEL_BIT];
      end else if (addr == ADDR_ECS) begin
        nxt_esel = wdata[SEL_BIT];
      end else if (addr == ADDR_KEY) begin
        nxt_key = wdata;
      end else if (addr == ADDR_DEST) begin
        nxt_dest = wdata[6:0];
        nxt_dest_err = wdata[DEST_ERR_BIT];
      end
    end

    // ************************************************************
    // register reads, data in the following cycle
    // ************************************************************
    if (rd) begin
      if (addr == ADDR_CCS) begin
        nxt_rdata[CCS_WP_BIT] = wp_ff;
        nxt_rdata[CCS_ERR_BIT] = err_ff;
        nxt_rdata[CCS_RELOC_BIT] = reloc_ff; // request bit reads 0
      end else if (addr == ADDR_PCS) begin
        nxt_rdata[SEL_BIT] = psel_ff;
      end else if (addr == ADDR_ECS) begin
        nxt_rdata[SEL_BIT] = esel_ff;
      end else if (addr == ADDR_KEY) begin
        nxt_rdata = key_ff;
      end else if (addr == ADDR_DEST) begin
        nxt_rdata = {dest_err_ff, dest_ff};
      end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    case (state_ff)
      ST_IDLE: begin
        if (prog_start || erase_start) begin
          if (start_ok && prog_start && prog_loaded_ff) begin
            nxt_state = ST_PROG;
            nxt_cnt = '0;
            nxt_faddr = {prog_page, 7'h00};
          end else if (start_ok && erase_start && erase_loaded_ff) begin
            nxt_state = ST_ERASE;
            nxt_fblock = erase_block;
            nxt_ferase = 1'b1;
          end else begin
            nxt_fail = 1'b1;
          end
        end
      end
      ST_DL_COPY: begin
        nxt_dl_wr = 1'b1;
        nxt_dl_addr = base_ff + 24'(cnt_ff);
        nxt_cnt = cnt_ff + CW'(1);
        if (cnt_ff == COPY_LAST) begin
          nxt_state = ST_IDLE;
          nxt_req = 1'b0;
          if (dl_rt_ff) begin
            nxt_esel = 1'b0;
            nxt_erase_loaded = 1'b1;
          end else begin
            nxt_psel = 1'b0;
            nxt_prog_loaded = 1'b1;
          end
        end
      end
      ST_PROG: begin
        // a whole 128-byte page is written per start; only an abort or standby leaves a partial page
        nxt_fprog = 1'b1;
        nxt_faddr = {faddr_ff[23:7], cnt_ff[6:0]};
        nxt_cnt = cnt_ff + CW'(1);
        if (cnt_ff[6:0] == PAGE_LAST) begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      ST_ERASE: begin
        if (flash_done) begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // abort beats completion: a pin drop or error leaves flash unfinished
    if (busy && (err_event || !wp_ff)) begin
      nxt_state = ST_IDLE;
      nxt_fprog = 1'b0;
      nxt_done = 1'b0;
      nxt_fail = 1'b1;
    end

    // standby acts like reset except on the counter, base, vector, read data and the dl_addr, dl_routine, flash_addr, flash_block outputs
    if (sb_ff) begin
      nxt_state = ST_IDLE;
      nxt_err = 1'b0;
      nxt_reloc = 1'b0;
      nxt_req = 1'b0;
      nxt_psel = 1'b0;
      nxt_esel = 1'b0;
      nxt_key = REG_RESET;
      nxt_dest = 7'h00;
      nxt_dest_err = 1'b0;
      nxt_prog_loaded = 1'b0;
      nxt_erase_loaded = 1'b0;
      nxt_dl_wr = 1'b0;
      nxt_fprog = 1'b0;
      nxt_ferase = 1'b0;
      nxt_done = 1'b0;
      nxt_fail = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      err_ff <= 1'b0;
      reloc_ff <= 1'b0;
      req_ff <= 1'b0;
      psel_ff <= 1'b0;
      esel_ff <= 1'b0;
      key_ff <= REG_RESET;
      dest_ff <= 7'h00;
      dest_err_ff <= 1'b0;
      prog_loaded_ff <= 1'b0;
      erase_loaded_ff <= 1'b0;
      cnt_ff <= '0;
      base_ff <= 24'h000000;
      rdata_ff <= REG_RESET;
      vec_ff <= 24'h000000;
      dl_wr_ff <= 1'b0;
      dl_addr_ff <= 24'h000000;
      dl_rt_ff <= 1'b0;
      fprog_ff <= 1'b0;
      ferase_ff <= 1'b0;
      faddr_ff <= 24'h000000;
      fblock_ff <= 4'h0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      err_ff <= nxt_err;
      reloc_ff <= nxt_reloc;
      req_ff <= nxt_req;
      psel_ff <= nxt_psel;
      esel_ff <= nxt_esel;
      key_ff <= nxt_key;
      dest_ff <= nxt_dest;
      dest_err_ff <= nxt_dest_err;
      prog_loaded_ff <= nxt_prog_loaded;
      erase_loaded_ff <= nxt_erase_loaded;
      cnt_ff <= nxt_cnt;
      base_ff <= nxt_base;
      rdata_ff <= nxt_rdata;
      vec_ff <= nxt_vec;
      dl_wr_ff <= nxt_dl_wr;
      dl_addr_ff <= nxt_dl_addr;
      dl_rt_ff <= nxt_dl_rt;
      fprog_ff <= nxt_fprog;
      ferase_ff <= nxt_ferase;
      faddr_ff <= nxt_faddr;
      fblock_ff <= nxt_fblock;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic busy_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state == ST_PROG) || (nxt_state == ST_ERASE);
    end
  end

  assign rdata = rdata_ff;
  assign vec_addr = vec_ff;
  assign dl_wr = dl_wr_ff;
  assign dl_addr = dl_addr_ff;
  assign dl_routine = dl_rt_ff;
  assign flash_prog = fprog_ff;
  assign flash_erase = ferase_ff;
  assign flash_addr = faddr_ff;
  assign flash_block = fblock_ff;
  assign pe_busy = busy_ff;
  assign pe_done = done_ff;
  assign pe_fail = fail_ff;
endmodule

// ### test/flash_dl_monitor.sv
`timescale 1ns/1ps
// *****
// port checks
// *****
module flash_dl_monitor
  import flash_dl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic wp_pin,
  input wire logic irq_event,
  input wire logic flash_read_event,
  input wire logic sleep_event,
  input wire logic other_master_event,
  input wire logic flash_done,
  input wire logic dl_wr,
  input wire logic [23:0] dl_addr,
  input wire logic flash_prog,
  input wire logic [23:0] flash_addr,
  input wire logic pe_busy,
  input wire logic pe_done,
  input wire logic pe_fail
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  req_zero_a: assert property (rd && addr == ADDR_CCS |=> !rdata[CCS_REQ_BIT])
    else $error("request bit read as one");
  irq_abort_a: assert property (pe_busy && (irq_event || flash_read_event) |-> ##[1:2] pe_fail)
    else $error("no abort on interrupt or read");
  sleep_abort_a: assert property (pe_busy && (sleep_event || other_master_event) |-> ##[1:2] pe_fail)
    else $error("no abort on sleep or other master");
  pin_abort_a: assert property (pe_busy ##0 !wp_pin [*5] |-> !pe_busy)
    else $error("busy with pin low");
  erase_end_a: assert property (pe_busy && flash_done |=> pe_done && !pe_busy)
    else $error("erase did not end");
  page_start_a: assert property ($rose(flash_prog) |-> flash_addr[6:0] == 7'h00)
    else $error("page not aligned");
  page_step_a: assert property (flash_prog && $past(flash_prog) |-> flash_addr == $past(flash_addr) + 24'h000001)
    else $error("page address skipped");
  copy_step_a: assert property (dl_wr && $past(dl_wr) |-> dl_addr == $past(dl_addr) + 24'h000001)
    else $error("copy address skipped");
endmodule
bind flash_program_download_control flash_dl_monitor i_mon (.clk, .rst, .addr, .rd, .rdata,
  .wp_pin, .irq_event, .flash_read_event, .sleep_event, .other_master_event, .flash_done,
  .dl_wr, .dl_addr, .flash_prog, .flash_addr, .pe_busy, .pe_done, .pe_fail);

// ### test/flash_program_download_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module flash_program_download_control_test
  import flash_dl_pkg::*;
;
  localparam int WORDS = 4;
  localparam int ERR_HOLD = 25000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wp_pin = 1'b1;
  logic standby_pin = 1'b0;
  logic exec_in_ram = 1'b1;
  logic [3:0] ev = 4'h0;
  logic prog_start = 1'b0;
  logic erase_start = 1'b0;
  logic [16:0] prog_page = 17'h00000;
  logic [3:0] erase_block = 4'h0;
  logic flash_done = 1'b0;
  logic [5:0] vec_num = 6'h00;
  logic [7:0] rdata, e8;
  logic [23:0] vec_addr, dl_addr, flash_addr;
  logic dl_wr, dl_routine, flash_prog, flash_erase, pe_busy, pe_done, pe_fail, rd_seen;
  logic [3:0] flash_block;
  logic [1:0] e2;
  logic [7:0] exp_q[$];
  logic [1:0] op_q[$];
  logic [23:0] bases[4] = '{DEST_BASE0, DEST_BASE1, DEST_BASE2, DEST_BASE3};
  int err_total = 0;
  int total_checks = 0;
  int beats = 0;
  int dlw = 0;
  int seed = 10660;
  int n;
  flash_program_download_control #(.ROUTINE_WORDS(WORDS)) i_flash_program_download_control (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wp_pin(wp_pin), .standby_pin(standby_pin), .exec_in_ram(exec_in_ram),
    .irq_event(ev[0]), .flash_read_event(ev[1]), .sleep_event(ev[2]),
    .other_master_event(ev[3]), .prog_start(prog_start), .erase_start(erase_start),
    .prog_page(prog_page), .erase_block(erase_block), .flash_done(flash_done),
    .vec_num(vec_num), .vec_addr(vec_addr), .dl_wr(dl_wr), .dl_addr(dl_addr),
    .dl_routine(dl_routine), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_block(flash_block), .pe_busy(pe_busy),
    .pe_done(pe_done), .pe_fail(pe_fail));
  initial begin
    forever #2 clk = ~clk;
  end
  // *****
  // result watcher: oldest note against what appears
  // *****
  always @(posedge clk) begin
    if (rd_seen === 1'b1) begin
      e8 = exp_q.pop_front();
      `CHK("rdata", e8, rdata)
    end
    if (pe_done === 1'b1 || pe_fail === 1'b1) begin
      e2 = (op_q.size() != 0) ? op_q.pop_front() : 2'b00;
      `CHK("op result", e2, {pe_done, pe_fail})
    end
    beats += (flash_prog === 1'b1);
    dlw += (dl_wr === 1'b1);
    rd_seen <= rd;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic rst_t(input logic sb, input int hold);
    rst <= !sb;
    standby_pin <= sb;
    cyc(hold);
    rst <= 1'b0;
    standby_pin <= 1'b0;
    cyc(4);
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_t(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op_t(input logic p, input logic [1:0] res);
    op_q.push_back(res);
    prog_start <= p;
    erase_start <= !p;
    @(posedge clk) prog_start <= 1'b0;
    erase_start <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_t(input int which);
    n = 0;
    while (n < 400 && (which == 0 ? op_q.size() != 0 :
        (which == 1 ? dl_wr : (which == 2 ? flash_prog : flash_erase)) !== 1'b1)) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) err_total++;
  endtask
  task automatic dl_t(input logic [7:0] sel, input logic [7:0] code, input logic [23:0] base);
    wr_t(sel, 8'h01);
    wr_t(ADDR_DEST, code);
    wr_t(ADDR_KEY, KEY_DOWNLOAD);
    wr_t(ADDR_CCS, 8'h01);
    wait_t(1);
    `CHK("copy base", base, dl_addr)
    `CHK("routine", sel == ADDR_ECS, dl_routine)
    cyc(WORDS + 2);
    rd_t(sel, 8'h00);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    rst_t(1'b0, 5);
    rd_t(ADDR_CCS, 8'h80);
    for (int a = 1; a < 8; a++) rd_t(8'(a), 8'h00);
    wr_t(ADDR_CCS, 8'h98);
    rd_t(ADDR_CCS, 8'h88);
    vec_num <= 6'($random(seed)) & 6'h1F;
    cyc(2);
    `CHK("vec reloc", RELOC_BASE + {16'h0000, vec_num, 2'b00}, vec_addr)
    wr_t(ADDR_CCS, 8'h00);
    vec_num <= 6'($random(seed)) | 6'h20;
    cyc(2);
    `CHK("vec high", {16'h0000, vec_num, 2'b00}, vec_addr)
    vec_num <= 6'($random(seed)) & 6'h1F;
    cyc(2);
    `CHK("vec plain", {16'h0000, vec_num, 2'b00}, vec_addr)
    wr_t(ADDR_PCS, 8'h01);
    wr_t(ADDR_CCS, 8'h01);
    exec_in_ram <= 1'b0;
    wr_t(ADDR_KEY, KEY_DOWNLOAD);
    wr_t(ADDR_CCS, 8'h01);
    cyc(WORDS + 4);
    rd_t(ADDR_PCS, 8'h01);
    exec_in_ram <= 1'b1;
    dl_t(ADDR_PCS, 8'h00, DEST_BASE0);
    rd_t(ADDR_CCS, 8'h80);
    wr_t(ADDR_ECS, 8'h01);
    wr_t(ADDR_DEST, 8'h05);
    wr_t(ADDR_CCS, 8'h01);
    cyc(WORDS + 4);
    rd_t(ADDR_DEST, 8'h85);
    rd_t(ADDR_ECS, 8'h01);
    wr_t(ADDR_ECS, 8'h00);
    wr_t(ADDR_DEST, 8'h00);
    wr_t(ADDR_CCS, 8'h01);
    cyc(WORDS + 4);
    `CHK("copied words", WORDS, dlw)
    dl_t(ADDR_ECS, 8'h01, DEST_BASE1);
    op_t(1'b1, 2'b01);
    wr_t(ADDR_KEY, KEY_PROGRAM);
    wp_pin <= 1'b0;
    cyc(4);
    op_t(1'b1, 2'b01);
    wp_pin <= 1'b1;
    cyc(4);
    erase_block <= 4'($random(seed));
    op_t(1'b0, 2'b10);
    wait_t(3);
    `CHK("erase block", erase_block, flash_block)
    `CHK("erase busy", 1'b1, pe_busy)
    cyc(3);
    flash_done <= 1'b1;
    @(posedge clk) flash_done <= 1'b0;
    wait_t(0);
    // pin dropped mid-erase: abort, but the error flag stays clear
    op_t(1'b0, 2'b01);
    wp_pin <= 1'b0;
    cyc(6);
    wp_pin <= 1'b1;
    cyc(4);
    rd_t(ADDR_CCS, 8'h80);
    for (int k = 0; k < 2; k++) begin
      prog_page <= 17'($random(seed));
      op_t(1'b1, 2'b10);
      wait_t(2);
      `CHK("page start", {prog_page, 7'h00}, flash_addr)
      wait_t(0);
    end
    `CHK("page bytes", 256, beats)
    // each fault source in turn; standby and reset must both clear the flag
    for (int e = 0; e < 4; e++) begin
      rst_t(e[0], (e == 2) ? ERR_HOLD : 5);
      rd_t(ADDR_CCS, 8'h80);
      dl_t(ADDR_ECS, 8'(e), bases[e]);
      wr_t(ADDR_KEY, KEY_PROGRAM);
      op_t(1'b0, 2'b01);
      ev[e] <= 1'b1;
      @(posedge clk) ev[e] <= 1'b0;
      wait_t(0);
      wr_t(ADDR_CCS, 8'h00);
      rd_t(ADDR_CCS, 8'h90);
      op_t(1'b0, 2'b01);
      wait_t(0);
    end
    end_of_test();
  end
endmodule
